// *** src/pss_params.svh ***
// constants of the card slot power switch control block: offsets, field positions, reset values
// assumes inclusion by bare name from the package and the design modules
`ifndef PSS_PARAMS_SVH
`define PSS_PARAMS_SVH

`define PSS_WORD_W 11
`define PSS_SD_BIT 8
`define PSS_CH_N 4
`define PSS_SEL_W 2
`define PSS_SEL_OFF 2'h0
`define PSS_SEL_HV 2'h3

`define PSS_NSYNC 9
`define PSS_PIN_RST 0
`define PSS_PIN_SHUTDOWN_N_PIN 1
`define PSS_PIN_HOT 2
`define PSS_PIN_SAFE 3
`define PSS_PIN_HV 4
`define PSS_PIN_OC 5

`define PSS_SER_DATA 0
`define PSS_SER_CLK 1
`define PSS_SER_LATCH 2

`define PSS_OFF_WORD 8'h00
`define PSS_OFF_SHIFT 8'h04
`define PSS_OFF_STATE 8'h08
`define PSS_OFF_IRQ_STATUS 8'h0c
`define PSS_OFF_IRQ_CLEAR 8'h10
`define PSS_OFF_IRQ_ENABLE 8'h14
`define PSS_OFF_CTRL 8'h18

`define PSS_NIRQ 4
`define PSS_IRQ_LATCHED 0
`define PSS_IRQ_FAULT 1
`define PSS_IRQ_HOT 2
`define PSS_IRQ_IGNORED 3

`define PSS_RST_WORD 11'h000
`define PSS_RST_IRQ_EN 4'h0
`define PSS_RST_CTRL_SD 1'b0

`endif

// *** src/pss_pkg.sv ***
// types of the card slot power switch control block
// assumes the params header is on the include path
`include "pss_params.svh"

package pss_pkg;

  typedef enum logic [1:0] {
    PSS_ST_GND = 2'b01,
    PSS_ST_RUN = 2'b10
  } pss_state_t;

  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic clk_d;
    logic latch_d;
    logic [`PSS_WORD_W-1:0] sr;
    logic lp;
  } pss_rx_t;

  typedef struct packed {
    logic [`PSS_NSYNC-1:0] s1;
    logic [`PSS_NSYNC-1:0] s2;
    pss_state_t st;
    logic [`PSS_WORD_W-1:0] word;
    logic ot;
    logic fault_d;
    logic ctrl_sd;
    logic [`PSS_NIRQ-1:0] irq_st;
    logic [`PSS_NIRQ-1:0] irq_en;
    logic irq;
    logic ph_act;
    logic ph_wr;
    logic ph_map;
    logic [7:0] ph_addr;
    logic [31:0] rdata;
    logic [`PSS_CH_N*`PSS_SEL_W-1:0] o_sel;
    logic [`PSS_CH_N-1:0] o_dis;
    logic [`PSS_CH_N-1:0] o_gnd;
    logic o_hiz;
    logic [1:0] o_hv;
    logic o_fault_n;
  } pss_core_t;

endpackage

// *** src/pss_ser_if.sv ***
// carrier between the serial receiver and the control core
// assumes both ends run on hclk
`timescale 1ns/10ps
`default_nettype none
`include "pss_params.svh"

interface pss_ser_if;
  logic [`PSS_WORD_W-1:0] shift_word;
  logic latch_pulse;
  modport rx (output shift_word, output latch_pulse);
  modport core (input shift_word, input latch_pulse);
endinterface

`default_nettype wire

// *** src/pss_serial_rx.sv ***
// three-wire serial receiver: synchronises data, clock and latch pins, shifts on clock rise
// assumes the serial clock is much slower than hclk (at least four hclk periods per level)
`timescale 1ns/10ps
`default_nettype none
`include "pss_params.svh"

module pss_serial_rx (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ser_data,
  input wire logic ser_clk,
  input wire logic ser_latch,
  pss_ser_if.rx ser
);

  pss_pkg::pss_rx_t q;
  pss_pkg::pss_rx_t n;
  logic clk_rise;

  // data and clock share the same sync depth, so data is seen as it stood at the clock edge
  assign clk_rise = q.s2[`PSS_SER_CLK] & ~q.clk_d;

  always_comb begin
    n = q;
    n.s1 = {ser_latch, ser_clk, ser_data};
    n.s2 = q.s1;
    n.clk_d = q.s2[`PSS_SER_CLK];
    n.latch_d = q.s2[`PSS_SER_LATCH];
    if (clk_rise) begin
      n.sr = {q.s2[`PSS_SER_DATA], q.sr[`PSS_WORD_W-1:1]};
    end
    n.lp = q.s2[`PSS_SER_LATCH] & ~q.latch_d;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign ser.shift_word = q.sr;
  assign ser.latch_pulse = q.lp;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_SHIFT_IN: assert property (clk_rise |=> q.sr[`PSS_WORD_W-1] == $past(q.s2[`PSS_SER_DATA]))
    else $error("serial bit not shifted in on clock rise");
  AST_LATCH_EDGE: assert property ($rose(q.s2[`PSS_SER_LATCH]) |=> q.lp ##1 !q.lp)
    else $error("latch rise did not give a single pulse");

endmodule

`default_nettype wire

// *** src/pss_top.sv ***
// card slot power switch control: serial control word, reset, shutdown, fault flag, AHB-Lite registers
// assumes a single AHB-Lite master, slow asynchronous slot pins, and analog status inputs with hysteresis
`timescale 1ns/10ps
`default_nettype none
`include "pss_params.svh"

module pss_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic ser_data,
  input wire logic ser_clk,
  input wire logic ser_latch,
  input wire logic reset_n_pin,
  input wire logic shutdown_n_pin,
  input wire logic temp_hot,
  input wire logic temp_safe,
  input wire logic hv_supply_present,
  input wire logic [`PSS_CH_N-1:0] overcurrent,
  output logic [3:0] slot_card_supply_out,
  output logic [3:0] slot_program_supply_out,
  output logic [1:0] slot_card_supply_dis,
  output logic [1:0] slot_program_supply_dis,
  output logic ground_switch_a,
  output logic ground_switch_b,
  output logic ground_switch_c,
  output logic ground_switch_d,
  output logic supply_hiz,
  output logic [1:0] gate_drive_from_hv,
  output logic fault_flag_n,
  output logic irq
);

  localparam pss_pkg::pss_core_t RST_Q = '{
    s1: '0,
    s2: '0,
    st: pss_pkg::PSS_ST_GND,
    word: `PSS_RST_WORD,
    ot: 1'b0,
    fault_d: 1'b0,
    ctrl_sd: `PSS_RST_CTRL_SD,
    irq_st: '0,
    irq_en: `PSS_RST_IRQ_EN,
    irq: 1'b0,
    ph_act: 1'b0,
    ph_wr: 1'b0,
    ph_map: 1'b0,
    ph_addr: 8'h00,
    rdata: 32'h0000_0000,
    o_sel: '0,
    o_dis: '0,
    o_gnd: '1,
    o_hiz: 1'b0,
    o_hv: 2'h0,
    o_fault_n: 1'b1
  };

  pss_ser_if ser ();

  pss_serial_rx u_rx (
    .hclk(hclk),
    .hresetn(hresetn),
    .ser_data(ser_data),
    .ser_clk(ser_clk),
    .ser_latch(ser_latch),
    .ser(ser.rx)
  );

  pss_pkg::pss_core_t q;
  pss_pkg::pss_core_t n;

  logic rst_s;
  logic shutdown_n_pin_s;
  logic hot_s;
  logic safe_s;
  logic hv_s;
  logic [`PSS_CH_N-1:0] oc_s;
  logic run;
  logic sd;
  logic take;
  logic ignored;
  logic fault;
  logic addr_valid;
  logic [`PSS_CH_N-1:0] ch_on;
  logic [`PSS_CH_N-1:0] ch_hv;
  logic [`PSS_CH_N*`PSS_SEL_W-1:0] ch_sel;
  logic [`PSS_NIRQ-1:0] ev;
  logic [`PSS_NIRQ-1:0] clr;

  // only the second sync stage is read by logic
  assign rst_s = q.s2[`PSS_PIN_RST];
  assign shutdown_n_pin_s = q.s2[`PSS_PIN_SHUTDOWN_N_PIN];
  assign hot_s = q.s2[`PSS_PIN_HOT];
  assign safe_s = q.s2[`PSS_PIN_SAFE];
  assign hv_s = q.s2[`PSS_PIN_HV];
  assign oc_s = q.s2[`PSS_PIN_OC +: `PSS_CH_N];

  assign run = (q.st == pss_pkg::PSS_ST_RUN);
  assign sd = !shutdown_n_pin_s || q.word[`PSS_SD_BIT] || q.ctrl_sd;
  assign take = ser.latch_pulse && rst_s;
  assign ignored = ser.latch_pulse && !rst_s;
  assign fault = (|oc_s) || q.ot;
  assign addr_valid = hsel && hready && htrans[1];

  // channel order: card A, program A, card B, program B; two select bits each
  genvar gi;
  generate
    for (gi = 0; gi < `PSS_CH_N; gi = gi + 1) begin : g_ch
      assign ch_sel[gi*`PSS_SEL_W +: `PSS_SEL_W] = q.word[gi*`PSS_SEL_W +: `PSS_SEL_W];
      assign ch_on[gi] = run && !sd && !q.ot && (ch_sel[gi*`PSS_SEL_W +: `PSS_SEL_W] != `PSS_SEL_OFF);
      // only program channels (odd) can take gate drive from the high-voltage supply
      assign ch_hv[gi] = (gi % 2 == 1) && ch_on[gi] && hv_s &&
                         (ch_sel[gi*`PSS_SEL_W +: `PSS_SEL_W] == `PSS_SEL_HV);
    end
  endgenerate

  always_comb begin
    n = q;
    ev = '0;
    clr = '0;
    n.s1 = {overcurrent, hv_supply_present, temp_safe, temp_hot, shutdown_n_pin, reset_n_pin};
    n.s2 = q.s1;

    // state and active word
    if (!rst_s) begin
      n.st = pss_pkg::PSS_ST_GND;
    end else if (take) begin
      n.st = pss_pkg::PSS_ST_RUN;
      n.word = ser.shift_word;
    end

    // hot sets, safe clears: two thresholds give the hysteresis
    if (hot_s) begin
      n.ot = 1'b1;
    end else if (safe_s) begin
      n.ot = 1'b0;
    end
    n.fault_d = fault;

    // switch outputs, registered one cycle behind the state
    for (int i = 0; i < `PSS_CH_N; i++) begin
      n.o_sel[i*`PSS_SEL_W +: `PSS_SEL_W] = ch_on[i] ? ch_sel[i*`PSS_SEL_W +: `PSS_SEL_W] : `PSS_SEL_OFF;
      n.o_dis[i] = run && !sd && !ch_on[i];
    end
    n.o_gnd = {`PSS_CH_N{!run}};
    n.o_hiz = run && sd;
    n.o_hv = {ch_hv[3], ch_hv[1]};
    n.o_fault_n = !fault;

    // bus address phase; read data is prepared here so that it stands in the data phase
    n.ph_act = addr_valid;
    n.ph_wr = hwrite && (hsize == 3'h2);
    n.ph_map = (haddr[31:8] == 24'h00_0000);
    n.ph_addr = haddr[7:0];
    n.rdata = 32'h0000_0000;
    if (addr_valid && !hwrite && haddr[31:8] == 24'h00_0000) begin
      case (haddr[7:0])
        `PSS_OFF_WORD: n.rdata = {21'h00_0000, q.word};
        `PSS_OFF_SHIFT: n.rdata = {21'h00_0000, ser.shift_word};
        `PSS_OFF_STATE: n.rdata = {26'h000_0000, rst_s, hv_s, q.ot, !q.o_fault_n, q.o_hiz, !run};
        `PSS_OFF_IRQ_STATUS: n.rdata = {28'h000_0000, q.irq_st};
        `PSS_OFF_IRQ_ENABLE: n.rdata = {28'h000_0000, q.irq_en};
        `PSS_OFF_CTRL: n.rdata = {31'h0000_0000, q.ctrl_sd};
        default: n.rdata = 32'h0000_0000;
      endcase
    end

    // bus data phase writes; unmapped and non-word writes are dropped
    if (q.ph_act && q.ph_wr && q.ph_map) begin
      case (q.ph_addr)
        `PSS_OFF_IRQ_CLEAR: clr = hwdata[`PSS_NIRQ-1:0];
        `PSS_OFF_IRQ_ENABLE: n.irq_en = hwdata[`PSS_NIRQ-1:0];
        `PSS_OFF_CTRL: n.ctrl_sd = hwdata[0];
        default: n.ctrl_sd = q.ctrl_sd;
      endcase
    end

    // an event in the same cycle as its clear stays set
    ev[`PSS_IRQ_LATCHED] = take;
    ev[`PSS_IRQ_FAULT] = fault && !q.fault_d;
    ev[`PSS_IRQ_HOT] = hot_s && !q.ot;
    ev[`PSS_IRQ_IGNORED] = ignored;
    n.irq_st = (q.irq_st & ~clr) | ev;
    n.irq = |(n.irq_st & n.irq_en);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= RST_Q;
    end else begin
      q <= n;
    end
  end

  assign hrdata = q.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign slot_card_supply_out = {q.o_sel[5:4], q.o_sel[1:0]};
  assign slot_program_supply_out = {q.o_sel[7:6], q.o_sel[3:2]};
  assign slot_card_supply_dis = {q.o_dis[2], q.o_dis[0]};
  assign slot_program_supply_dis = {q.o_dis[3], q.o_dis[1]};
  assign ground_switch_a = q.o_gnd[0];
  assign ground_switch_b = q.o_gnd[1];
  assign ground_switch_c = q.o_gnd[2];
  assign ground_switch_d = q.o_gnd[3];
  assign supply_hiz = q.o_hiz;
  assign gate_drive_from_hv = q.o_hv;
  assign fault_flag_n = q.o_fault_n;
  assign irq = q.irq;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_LATCH_COPY: assert property (take |=> q.word == $past(ser.shift_word) && run)
    else $error("latched word differs from shift register");
  AST_HOLD_WORD: assert property (!ser.latch_pulse |=> $stable(q.word))
    else $error("active word changed without latch");
  AST_RESET_IGNORES: assert property (!rst_s && ser.latch_pulse |=> $stable(q.word) && !run)
    else $error("latch taken while reset pin low");
  AST_RESET_GROUND: assert property (!rst_s |=> ##1 (q.o_gnd == '1 && q.o_sel == '0 && q.o_dis == '0 && !q.o_hiz))
    else $error("reset did not ground outputs alone");
  AST_STAY_GROUNDED: assert property (!run && !take |=> !run ##1 ground_switch_a)
    else $error("left grounded state without a latch");
  AST_SHUTDOWN_HIZ: assert property (run && (!shutdown_n_pin_s || q.word[`PSS_SD_BIT]) |=> supply_hiz && q.o_sel == '0)
    else $error("shutdown did not float outputs");
  AST_FAULT_LOW: assert property ((|oc_s) || q.ot |=> !fault_flag_n)
    else $error("fault flag not low during fault");
  AST_FAULT_HIGH: assert property (!(|oc_s) && !q.ot |=> fault_flag_n)
    else $error("fault flag low without fault");
  AST_HOT_OFF: assert property (q.ot |=> q.o_sel == '0 && gate_drive_from_hv == 2'h0)
    else $error("output on during overtemperature");
  AST_HV_GATE: assert property (run && !sd && !q.ot && hv_s && q.word[3:2] == `PSS_SEL_HV
                                |=> gate_drive_from_hv[0])
    else $error("gate drive not taken from high-voltage supply");
  AST_DISCHARGE: assert property (run && !sd && q.word[1:0] == `PSS_SEL_OFF |=> slot_card_supply_dis[0])
    else $error("discharge off on a switched-off output");

  COV_LATCH: cover property (take ##1 run);
  COV_SHUTDOWN: cover property (run && sd ##1 supply_hiz);
  COV_FAULT: cover property ($fell(fault_flag_n));
  COV_IGNORED: cover property (ignored);

endmodule

`default_nettype wire

// *** tb/pss_host_model.sv ***
// serial host controller model: shifts an 11-bit control word out on data, clock and latch
// assumes the device samples these pins with its own clock; link clock period 200 ns, idle between frames
`timescale 1ns/10ps
`default_nettype none

module pss_host_model (
  output var logic ser_data,
  output var logic ser_clk,
  output var logic ser_latch
);
  initial begin
    ser_data = 1'b0;
    ser_clk = 1'b0;
    ser_latch = 1'b0;
  end

  // first bit sent ends in bit 0; leaving out the latch tests that the active word holds
  task automatic send(input logic [10:0] w, input bit do_latch);
    for (int i = 0; i < 11; i++) begin
      ser_data = w[i];
      #100 ser_clk = 1'b1;
      #100 ser_clk = 1'b0;
    end
    if (do_latch) begin
      #100 ser_latch = 1'b1;
      #100 ser_latch = 1'b0;
    end
    // released data line shows no stale bit
    ser_data = ~ser_data;
    #100;
  endtask
endmodule

`default_nettype wire

// *** tb/pss_top_test.sv ***
// self-checking testbench of the card slot power switch control block
// assumes the design sources and the serial host model are compiled before it
`timescale 1ns/10ps
`default_nettype none
`include "pss_params.svh"

module pss_top_test;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, rd_ph;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, card_dis, prog_dis, hv_gate;
  logic [2:0] hsize;
  logic ser_data, ser_clk, ser_latch, reset_n_pin, shutdown_n_pin, temp_hot, temp_safe, hv_supply_present;
  logic [3:0] overcurrent, card_out, prog_out, gnd;
  logic supply_hiz, fault_flag_n, irq;
  logic [31:0] exp_q[$];
  logic [10:0] w1, w2;
  int miscompares = 0;
  int n_compared = 0;

  assign hready = hreadyout;

  pss_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .ser_data(ser_data), .ser_clk(ser_clk), .ser_latch(ser_latch), .reset_n_pin(reset_n_pin),
    .shutdown_n_pin(shutdown_n_pin), .temp_hot(temp_hot), .temp_safe(temp_safe),
    .hv_supply_present(hv_supply_present), .overcurrent(overcurrent), .slot_card_supply_out(card_out),
    .slot_program_supply_out(prog_out), .slot_card_supply_dis(card_dis), .slot_program_supply_dis(prog_dis),
    .ground_switch_a(gnd[0]), .ground_switch_b(gnd[1]), .ground_switch_c(gnd[2]), .ground_switch_d(gnd[3]),
    .supply_hiz(supply_hiz), .gate_drive_from_hv(hv_gate), .fault_flag_n(fault_flag_n), .irq(irq));

  pss_host_model host (.ser_data(ser_data), .ser_clk(ser_clk), .ser_latch(ser_latch));

  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  task automatic print_verdict();
    if (miscompares == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  // one single transfer; a read notes its expected data for the monitor
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    hsize <= 3'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0;
    if (!wr) exp_q.push_back(d);
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask

  always @(posedge hclk) begin
    if (!hresetn) rd_ph = 1'b0;
    else begin
      if (rd_ph && hreadyout && exp_q.size() > 0) check("hrdata", hrdata, exp_q.pop_front());
      if (hreadyout) rd_ph = hsel && htrans[1] && !hwrite;
    end
  end

  task automatic settle(input int n);
    repeat (n) @(posedge hclk);
    @(negedge hclk);
  endtask

  task automatic grounded();
    check("ground", gnd, 4'hf);
    check("card", {card_out, prog_out}, 8'h00);
  endtask

  task automatic running(input logic [10:0] w);
    check("card", card_out, {w[5:4], w[1:0]});
    check("prog", prog_out, {w[7:6], w[3:2]});
    check("dis", {card_dis, prog_dis}, {w[5:4] == 0, w[1:0] == 0, w[7:6] == 0, w[3:2] == 0});
    check("ground", gnd, 4'h0);
    check("hiz", supply_hiz, w[8]);
  endtask

  task automatic frame(input logic [10:0] w, input bit lat);
    host.send(w, lat);
    settle(10);
  endtask

  initial begin
    {hsel, hwrite, hresetn, temp_hot, temp_safe, hv_supply_present} = '0;
    {haddr, hwdata, htrans, overcurrent, reset_n_pin} = '0;
    hsize = 3'b010;
    shutdown_n_pin = 1'b1;
    void'($urandom(32'h8d04889f));
    w1 = 11'($urandom() & 32'h0ff);
    w2 = 11'($urandom() & 32'h0ff) | 11'h001;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    settle(2);
    grounded();
    check("idle", {irq, fault_flag_n, hreadyout, hresp}, 4'b0110);
    bus(`PSS_OFF_IRQ_ENABLE, 1'b0, 32'h0);
    bus(`PSS_OFF_CTRL, 1'b0, 32'h0);
    bus(8'h1c, 1'b1, 32'hffff_ffff);
    bus(8'h1c, 1'b0, 32'h0);
    bus(`PSS_OFF_WORD, 1'b1, 32'h7ff);
    frame(w1, 1'b1);
    grounded();
    bus(`PSS_OFF_WORD, 1'b0, 32'h0);
    bus(`PSS_OFF_IRQ_STATUS, 1'b0, 32'h8);
    bus(`PSS_OFF_IRQ_CLEAR, 1'b1, 32'h8);
    @(posedge hclk) reset_n_pin <= 1'b1;
    settle(8);
    grounded();
    bus(`PSS_OFF_IRQ_ENABLE, 1'b1, 32'h1);
    frame(w1, 1'b1);
    running(w1);
    check("irq", irq, 1'b1);
    bus(`PSS_OFF_IRQ_CLEAR, 1'b1, 32'h1);
    settle(2);
    check("irq", irq, 1'b0);
    frame(w2, 1'b0);
    running(w1);
    bus(`PSS_OFF_WORD, 1'b0, {21'h0, w1});
    bus(`PSS_OFF_SHIFT, 1'b0, {21'h0, w2});
    frame(w2, 1'b1);
    running(w2);
    bus(`PSS_OFF_IRQ_ENABLE, 1'b1, 32'h0);
    settle(2);
    check("irq", irq, 1'b0);
    // code 2 stands for the higher card supply, code 1 for the lower
    frame(11'h002, 1'b1);
    bus(`PSS_OFF_WORD, 1'b0, 32'h002);
    frame(11'h000, 1'b1);
    check("dis", card_dis, 2'b11);
    frame(11'h001, 1'b1);
    running(11'h001);
    frame(w2 | 11'h100, 1'b1);
    check("hiz", supply_hiz, 1'b1);
    frame(11'h00c, 1'b1);
    bus(`PSS_OFF_CTRL, 1'b1, 32'h1);
    settle(2);
    check("hiz", supply_hiz, 1'b1);
    bus(`PSS_OFF_STATE, 1'b0, 32'h22);
    bus(`PSS_OFF_CTRL, 1'b1, 32'h0);
    @(posedge hclk) shutdown_n_pin <= 1'b0;
    settle(8);
    check("hiz", supply_hiz, 1'b1);
    @(posedge hclk) shutdown_n_pin <= 1'b1;
    hv_supply_present <= 1'b1;
    settle(8);
    check("hiz", supply_hiz, 1'b0);
    check("hv", hv_gate, 2'b01);
    bus(`PSS_OFF_IRQ_ENABLE, 1'b1, 32'h2);
    @(posedge hclk) overcurrent <= 4'($urandom_range(15, 1));
    settle(8);
    check("fault", {fault_flag_n, irq}, 2'b01);
    @(posedge hclk) overcurrent <= 4'h0;
    temp_hot <= 1'b1;
    settle(8);
    check("prog", {prog_out, fault_flag_n}, 5'h00);
    @(posedge hclk) temp_hot <= 1'b0;
    temp_safe <= 1'b1;
    hv_supply_present <= 1'b0;
    settle(8);
    check("prog", {prog_out, fault_flag_n, hv_gate}, 7'h1c);
    bus(`PSS_OFF_IRQ_CLEAR, 1'b1, 32'h2);
    settle(2);
    check("irq", irq, 1'b0);
    bus(`PSS_OFF_IRQ_STATUS, 1'b0, 32'h5);
    @(posedge hclk) reset_n_pin <= 1'b0;
    settle(8);
    grounded();
    bus(`PSS_OFF_STATE, 1'b0, 32'h1);
    print_verdict();
  end

  initial begin
    #2000000;
    miscompares++;
    print_verdict();
  end
endmodule

`default_nettype wire
